// ==== rtl/fdc_scan_ctrl.sv ====
`timescale 1ns/1ps
// Summary of operation
// (R1) unsigned byte compare, FF largest, 00 smallest
// (R2) failed sector: add step, continue scanning
// (R3) step one contiguous, step two alternate sectors
// (R4) condition met sets hit flag, ends
// (R5) none through end sector sets miss flag
// (R6) terminal count finishes current byte, then ends
// (R7) skip clear: deleted sector is final, mark
// (R8) skip set: bypass deleted sector, still mark
// (R9) host byte late past 13 us: overrun
// (R10) interrupt on result, seek end, transfer
// (R11) status query clears interrupt, reports cause
// (R12) query with nothing pending returns 80h
// (R13) head bit in returned status reads zero
// (R14) step rate code sets step interval
// (R15) unload code sets head unload delay
// (R16) load code sets head load delay
// (R17) non-DMA select picks request bit path
// (R18) implied seek enable forces seek first
// (R19) FIFO disable: threshold reads one byte, FIFO stays in path
// (R20) threshold field selects 1 to 16
// (R21) precomp track field, default track zero
// (R22) polling: one interrupt after reset
module fdc_scan_ctrl
  import fdc_cmd_pkg::*;
#(
  parameter int OVR_CYCLES  = OVERRUN_CYC,
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int FIFO_DEPTH  = 8
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       cfg_we,
  input  wire config_s    cfg_in,
  input  wire logic       spec_we,
  input  wire specify_s   spec_in,
  output config_s         cfg_out,
  output specify_s        spec_out,
  input  wire logic [1:0] rate_mult,
  input  wire logic       scan_start,
  input  wire logic [1:0] scan_mode,
  input  wire logic [7:0] start_sector,
  input  wire logic [7:0] end_track_sector,
  input  wire logic [7:0] sector_step_value,
  input  wire logic       skip_deleted_option,
  input  wire logic [7:0] disk_data,
  input  wire logic       disk_valid,
  input  wire logic       disk_last,
  input  wire logic       disk_deleted,
  output logic            disk_ready,
  input  wire logic [7:0] host_data,
  input  wire logic       host_valid,
  output logic            host_ready,
  input  wire logic       terminal_count_pin,
  output logic [7:0]      sector_req,
  output logic            scan_busy,
  output logic            scan_done,
  output result_s         scan_result,
  input  wire logic       result_phase_evt,
  input  wire logic       seek_done_evt,
  input  wire logic       seek_abnormal,
  input  wire logic [7:0] present_cylinder,
  input  wire logic       sense_int_cmd,
  output logic [7:0]      sense_st0,
  output logic [7:0]      sense_pcn,
  output logic            int_out,
  output logic            request_for_master_bit,
  output logic            dma_request_pin,
  input  wire logic       rw_cmd_start,
  input  wire logic       rw_exec_end,
  output logic            implied_seek_req,
  output logic            head_load_done,
  output logic            head_loaded,
  output logic            step_tick,
  output logic [4:0]      xfer_threshold
);
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_CMP  = 4'b0010,
    S_SKIP = 4'b0100,
    S_END  = 4'b1000
  } scan_st_e;

  scan_st_e       st_r, st_nxt;
  config_s        cfg_r, cfg_nxt;
  specify_s       spec_r, spec_nxt;
  result_s        res_r, res_nxt;
  logic [7:0]     sec_r, sec_nxt;
  logic           fail_r, fail_nxt;
  logic           tc_r, tc_nxt;
  logic [15:0]    ovr_r, ovr_nxt;
  logic           int_r, int_nxt;
  logic [1:0]     cause_r, cause_nxt;
  logic           poll_pend_r, poll_pend_nxt;
  logic [7:0]     s0_r, s0_nxt;
  logic [7:0]     pcn_r, pcn_nxt;
  logic           done_r, done_nxt;
  logic           tc_s1_r, tc_s2_r;
  logic [7:0]     hd;
  logic           hv, hr, pair;
  logic           match_byte;

  assign cfg_out  = cfg_r;
  assign spec_out = spec_r;
  assign xfer_threshold = cfg_r.fifo_disable_bit ? 5'h01 :
                          {1'b0, cfg_r.fifo_threshold_field} + 5'h01;  // see (R19) (R20)

  // host bytes buffered; source stalls once full
  fdc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .flush     (scan_start),
    .in_data   (host_data),
    .in_valid  (host_valid),
    .in_ready  (host_ready),
    .out_data  (hd),
    .out_valid (hv),
    .out_ready (hr)
  );

  assign pair       = (st_r == S_CMP) && disk_valid && hv;
  assign hr         = pair || (st_r == S_SKIP && disk_valid && hv);
  assign disk_ready = (st_r == S_CMP || st_r == S_SKIP) && hv;  // keeps host bytes paired

  always_comb begin
    case (scan_mode_e'(scan_mode))  // see (R1)
      SCAN_EQ: match_byte = (disk_data == hd);
      SCAN_LE: match_byte = (disk_data <= hd);
      SCAN_HE: match_byte = (disk_data >= hd);
      default: match_byte = (disk_data == hd);
    endcase
  end

  always_comb begin
    st_nxt   = st_r;
    res_nxt  = res_r;
    sec_nxt  = sec_r;
    fail_nxt = fail_r;
    tc_nxt   = tc_r | tc_s2_r;
    ovr_nxt  = ovr_r;
    done_nxt = 1'b0;
    case (st_r)
      S_IDLE: begin
        if (scan_start) begin
          st_nxt   = S_CMP;
          res_nxt  = '0;
          sec_nxt  = start_sector;
          fail_nxt = 1'b0;
          tc_nxt   = 1'b0;
          ovr_nxt  = '0;
        end
      end
      S_CMP: begin
        if (disk_valid && disk_deleted) begin
          res_nxt.st2[ST2_MARK_BIT] = 1'b1;  // see (R7) (R8)
          if (skip_deleted_option) begin
            st_nxt = S_SKIP;  // see (R8)
          end else begin
            st_nxt = S_END;  // see (R7)
          end
        end else if (pair) begin
          ovr_nxt = '0;
          if (!match_byte) begin
            fail_nxt = 1'b1;
          end
          if (tc_r || tc_s2_r) begin
            st_nxt = S_END;  // see (R6)
          end else if (disk_last) begin
            if (!fail_r && match_byte) begin
              res_nxt.st2[ST2_HIT_BIT] = 1'b1;  // see (R4)
              st_nxt = S_END;
            end else if (sec_r >= end_track_sector) begin
              res_nxt.st2[ST2_MISS_BIT] = 1'b1;  // see (R5)
              st_nxt = S_END;
            end else begin
              sec_nxt  = sec_r + sector_step_value;  // see (R2) (R3)
              fail_nxt = 1'b0;
            end
          end
        end else if (disk_valid && !hv) begin
          if (ovr_r >= 16'(OVR_CYCLES)) begin
            res_nxt.st1[ST1_OVERRUN_BIT] = 1'b1;  // see (R9)
            res_nxt.status_reg_zero[7:6] = CC_ABNORMAL;
            st_nxt = S_END;
          end else begin
            ovr_nxt = ovr_r + 16'h0001;
          end
        end else if (tc_r) begin
          st_nxt = S_END;  // see (R6)
        end
      end
      S_SKIP: begin
        if (disk_valid && hv && disk_last) begin  // see (R8)
          if (sec_r >= end_track_sector) begin
            res_nxt.st2[ST2_MISS_BIT] = 1'b1;
            st_nxt = S_END;
          end else begin
            sec_nxt = sec_r + sector_step_value;
            st_nxt  = S_CMP;
          end
        end
      end
      S_END: begin
        res_nxt.sector = sec_r;
        done_nxt       = 1'b1;
        st_nxt         = S_IDLE;
      end
      default: st_nxt = S_IDLE;
    endcase
  end

  // interrupt source and status query
  always_comb begin
    cfg_nxt       = cfg_we ? cfg_in : cfg_r;
    spec_nxt      = spec_we ? spec_in : spec_r;
    int_nxt       = int_r;
    cause_nxt     = cause_r;
    poll_pend_nxt = poll_pend_r;
    s0_nxt        = s0_r;
    pcn_nxt       = pcn_r;
    if (sense_int_cmd) begin
      int_nxt = 1'b0;  // see (R11)
      if (!int_r) begin
        s0_nxt = ST0_INVALID;  // see (R12)
      end else begin
        s0_nxt = '0;
        s0_nxt[7:6] = cause_r;
        s0_nxt[ST0_SEEK_END_BIT] = (cause_r != CC_POLL);  // see (R11)
        s0_nxt[ST0_HEAD_BIT]     = 1'b0;  // see (R13)
      end
      pcn_nxt = present_cylinder;
    end
    // new events win over a same-cycle clear
    if (seek_done_evt) begin
      int_nxt   = 1'b1;  // see (R10)
      cause_nxt = seek_abnormal ? CC_ABNORMAL : CC_NORMAL;
    end else if (poll_pend_r && !head_loaded && !cfg_r.poll_disable) begin
      int_nxt   = 1'b1;  // see (R22)
      cause_nxt = CC_POLL;
      poll_pend_nxt = 1'b0;  // one poll interrupt, else a query re-raises it
    end
    if (result_phase_evt || done_r) begin
      int_nxt = 1'b1;  // see (R10)
    end
  end

  assign request_for_master_bit = spec_r.non_dma_select && !hv && st_r == S_CMP;  // see (R17)
  assign dma_request_pin = !spec_r.non_dma_select && host_ready && st_r == S_CMP;  // see (R17)
  assign int_out   = int_r || request_for_master_bit;  // see (R10)
  assign scan_busy = (st_r != S_IDLE);
  assign sector_req = sec_r;

  // 0.5 ms base tick scaled by the data rate multiplier
  logic [31:0] tick_cnt_r;
  logic [1:0]  mul_r;
  logic        tick;
  logic [8:0]  step_cnt_r, step_cnt_nxt;
  logic [9:0]  unl_cnt_r, unl_cnt_nxt;
  logic [9:0]  load_cnt_r, load_cnt_nxt;
  logic        loaded_r, loaded_nxt, loading_r, loading_nxt;
  logic        seek_req_r, seek_req_nxt, ld_done_r, ld_done_nxt;
  logic [9:0]  unl_len, load_len;

  assign tick     = (tick_cnt_r == 32'(TICK_CYCLES - 1)) && (mul_r == rate_mult);
  assign unl_len  = (spec_r.head_unload_code == 4'h0) ? 10'(UNLOAD_ZERO_CNT) :
                    10'(spec_r.head_unload_code) * 10'(UNLOAD_PER_CNT);  // see (R15)
  assign load_len = (spec_r.head_load_code == 7'h00) ? 10'(LOAD_ZERO_CNT) :
                    10'(spec_r.head_load_code) * 10'(LOAD_PER_CNT);  // see (R16)

  always_comb begin
    step_cnt_nxt = step_cnt_r;
    unl_cnt_nxt  = unl_cnt_r;
    load_cnt_nxt = load_cnt_r;
    loaded_nxt   = loaded_r;
    loading_nxt  = loading_r;
    seek_req_nxt = 1'b0;
    ld_done_nxt  = 1'b0;
    if (tick) begin
      if (step_cnt_r >= 9'(STEP_BASE_TICKS) - 9'(spec_r.step_rate_code)) begin
        step_cnt_nxt = 9'h001;  // see (R14)
      end else begin
        step_cnt_nxt = step_cnt_r + 9'h001;
      end
    end
    if (rw_cmd_start) begin
      seek_req_nxt = cfg_r.implied_seek_enable;  // see (R18)
      loading_nxt  = 1'b1;
      load_cnt_nxt = '0;
    end else if (loading_r && tick) begin
      if (load_cnt_r + 10'h001 >= load_len) begin
        loading_nxt = 1'b0;
        loaded_nxt  = 1'b1;
        ld_done_nxt = 1'b1;
      end else begin
        load_cnt_nxt = load_cnt_r + 10'h001;
      end
    end
    if (rw_exec_end) begin
      unl_cnt_nxt = '0;
    end else if (loaded_r && !loading_r && tick) begin
      if (unl_cnt_r + 10'h001 >= unl_len) begin
        loaded_nxt = 1'b0;
      end else begin
        unl_cnt_nxt = unl_cnt_r + 10'h001;
      end
    end
  end

  assign step_tick        = tick && (step_cnt_r == 9'h001);
  assign implied_seek_req = seek_req_r;
  assign head_load_done   = ld_done_r;
  assign head_loaded      = loaded_r;

  always_ff @(posedge clk_sys) begin
    tc_s1_r <= terminal_count_pin;
    tc_s2_r <= tc_s1_r;
    if (rst) begin
      st_r        <= S_IDLE;
      res_r       <= '0;
      sec_r       <= '0;
      fail_r      <= 1'b0;
      tc_r        <= 1'b0;
      ovr_r       <= '0;
      done_r      <= 1'b0;
      cfg_r       <= '{RST_IMPLIED_SEEK, RST_FIFO_DISABLE, RST_POLL_DISABLE,
                       RST_FIFO_THR, RST_PRECOMP, 1'b0};  // see (R18) (R19) (R20) (R21)
      spec_r      <= '0;
      int_r       <= 1'b0;
      cause_r     <= CC_POLL;
      poll_pend_r <= 1'b1;  // see (R22)
      s0_r        <= '0;
      pcn_r       <= '0;
      tick_cnt_r  <= '0;
      mul_r       <= '0;
      step_cnt_r  <= '0;
      unl_cnt_r   <= '0;
      load_cnt_r  <= '0;
      loaded_r    <= 1'b0;
      loading_r   <= 1'b0;
      seek_req_r  <= 1'b0;
      ld_done_r   <= 1'b0;
    end else begin
      st_r        <= st_nxt;
      res_r       <= res_nxt;
      sec_r       <= sec_nxt;
      fail_r      <= fail_nxt;
      tc_r        <= tc_nxt;
      ovr_r       <= ovr_nxt;
      done_r      <= done_nxt;
      cfg_r       <= cfg_nxt;
      spec_r      <= spec_nxt;
      int_r       <= int_nxt;
      cause_r     <= cause_nxt;
      poll_pend_r <= poll_pend_nxt;
      s0_r        <= s0_nxt;
      pcn_r       <= pcn_nxt;
      if (tick_cnt_r == 32'(TICK_CYCLES - 1)) begin
        tick_cnt_r <= '0;
        mul_r      <= (mul_r == rate_mult) ? 2'h0 : mul_r + 2'h1;
      end else begin
        tick_cnt_r <= tick_cnt_r + 32'h1;
      end
      step_cnt_r  <= step_cnt_nxt;
      unl_cnt_r   <= unl_cnt_nxt;
      load_cnt_r  <= load_cnt_nxt;
      loaded_r    <= loaded_nxt;
      loading_r   <= loading_nxt;
      seek_req_r  <= seek_req_nxt;
      ld_done_r   <= ld_done_nxt;
    end
  end

  assign scan_done   = done_r;
  assign scan_result = res_r;
  assign sense_st0   = s0_r;
  assign sense_pcn   = pcn_r;
endmodule

// ==== rtl/fdc_cmd_pkg.sv ====
package fdc_cmd_pkg;
  // timing in microseconds at 1 Mbps; tick-based delays scale by the rate multiplier, the overrun limit does not
  localparam int    CLK_MHZ          = 200;
  localparam int    OVERRUN_US       = 13;
  localparam int    OVERRUN_CYC      = (OVERRUN_US * CLK_MHZ) - 1;
  localparam int    TICK_US          = 500;
  localparam int    TICK_CYC         = TICK_US * CLK_MHZ;
  localparam int    STEP_BASE_TICKS  = 16;
  localparam int    UNLOAD_ZERO_CNT  = 256;
  localparam int    UNLOAD_PER_CNT   = 16;
  localparam int    LOAD_PER_CNT     = 2;
  localparam int    LOAD_ZERO_CNT    = 256;
  localparam logic [7:0] ST0_INVALID = 8'h80;
  localparam logic [1:0] CC_NORMAL   = 2'h0;
  localparam logic [1:0] CC_ABNORMAL = 2'h1;
  localparam logic [1:0] CC_POLL     = 2'h3;
  localparam int    ST2_MISS_BIT     = 2;
  localparam int    ST2_HIT_BIT      = 3;
  localparam int    ST2_MARK_BIT     = 6;
  localparam int    ST1_OVERRUN_BIT  = 4;
  localparam int    ST0_SEEK_END_BIT = 5;
  localparam int    ST0_HEAD_BIT     = 2;
  localparam logic  RST_IMPLIED_SEEK = 1'b0;
  localparam logic  RST_FIFO_DISABLE = 1'b1;
  localparam logic [3:0] RST_FIFO_THR  = 4'h0;
  localparam logic [7:0] RST_PRECOMP   = 8'h00;
  localparam logic  RST_POLL_DISABLE = 1'b0;

  typedef enum logic [1:0] {
    SCAN_EQ = 2'h0,
    SCAN_LE = 2'h1,
    SCAN_HE = 2'h2
  } scan_mode_e;

  typedef struct packed {
    logic       implied_seek_enable;
    logic       fifo_disable_bit;
    logic       poll_disable;
    logic [3:0] fifo_threshold_field;
    logic [7:0] precomp_track_field;
    logic       double_freq_clock_select;
  } config_s;

  typedef struct packed {
    logic [3:0] step_rate_code;
    logic [3:0] head_unload_code;
    logic [6:0] head_load_code;
    logic       non_dma_select;
  } specify_s;

  typedef struct packed {
    logic [7:0] status_reg_zero;
    logic [7:0] st1;
    logic [7:0] st2;
    logic [7:0] sector;
  } result_s;
endpackage

// ==== rtl/fdc_fifo.sv ====
`timescale 1ns/1ps
module fdc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic [AW-1:0]    wp_nxt;
  logic [AW-1:0]    rp_nxt;
  logic [AW:0]      cnt_nxt;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    wp_nxt  = push ? ((wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1) : wp_r;
    rp_nxt  = pop ? ((rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1) : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    if (flush) begin
      wp_nxt  = '0;
      rp_nxt  = '0;
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
endmodule

// ==== verification/fdc_scan_checker.sv ====
`timescale 1ns/1ps
module fdc_scan_checker
  import fdc_cmd_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       cfg_we,
  input wire config_s    cfg_in,
  input wire config_s    cfg_out,
  input wire specify_s   spec_out,
  input wire logic       scan_start,
  input wire logic       scan_busy,
  input wire logic       scan_done,
  input wire result_s    scan_result,
  input wire logic       seek_done_evt,
  input wire logic       result_phase_evt,
  input wire logic       sense_int_cmd,
  input wire logic [7:0] sense_st0,
  input wire logic       int_out,
  input wire logic       request_for_master_bit,
  input wire logic       dma_request_pin,
  input wire logic       implied_seek_req,
  input wire logic [4:0] xfer_threshold
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_start_idle;
    scan_start && !scan_busy;
  endsequence
  sequence s_seek_evt;
    seek_done_evt && !sense_int_cmd;
  endsequence
  sequence s_ovr_end;
    scan_done ##1 scan_result.st1[ST1_OVERRUN_BIT];
  endsequence
  // quiet sense: no seek, result or scan cause can re-raise the line in the same cycle
  sequence s_quiet_sense;
    sense_int_cmd && !seek_done_evt && !result_phase_evt && !scan_busy && !scan_done
      && !spec_out.non_dma_select;
  endsequence

  a_thr_map: assert property (xfer_threshold ==
    (cfg_out.fifo_disable_bit ? 5'h01 : {1'b0, cfg_out.fifo_threshold_field} + 5'h01))
    else $error("threshold map wrong");
  a_cfg_load: assert property (cfg_we |=> cfg_out == $past(cfg_in))
    else $error("config not loaded");
  a_dma_path: assert property (dma_request_pin |-> !spec_out.non_dma_select)
    else $error("dma request in non-dma mode");
  a_rqm_path: assert property (request_for_master_bit |-> spec_out.non_dma_select)
    else $error("master request in dma mode");
  a_seek_int: assert property (s_seek_evt |=> int_out)
    else $error("seek end without interrupt");
  a_sense_clear: assert property (s_quiet_sense |=> !int_out)
    else $error("sense left interrupt set");
  a_sense_head: assert property (sense_int_cmd |=> sense_st0[ST0_HEAD_BIT] == 1'b0)
    else $error("head bit set in sense status");
  a_sense_idle: assert property (s_quiet_sense ##0 !int_out
    |=> sense_st0 == ST0_INVALID)
    else $error("idle sense not invalid");
  a_ovr_code: assert property (s_ovr_end |-> scan_result.status_reg_zero[7:6] == 2'h1)
    else $error("overrun without abnormal code");
  a_start_busy: assert property (s_start_idle |=> scan_busy)
    else $error("scan did not start");
  a_seek_gate: assert property (implied_seek_req
    |-> $past(cfg_out.implied_seek_enable))
    else $error("implied seek while disabled");
endmodule

bind fdc_scan_ctrl fdc_scan_checker u_chk (
  .clk_sys, .rst, .cfg_we, .cfg_in, .cfg_out, .spec_out, .scan_start, .scan_busy,
  .scan_done, .scan_result, .seek_done_evt, .result_phase_evt, .sense_int_cmd, .sense_st0,
  .int_out, .request_for_master_bit, .dma_request_pin, .implied_seek_req, .xfer_threshold
);

// ==== verification/fdc_host_model.sv ====
`timescale 1ns/1ps
module fdc_host_model (
  input wire logic  clk_sys,
  input wire logic  rst,
  input wire logic  slow_mode,
  output logic [7:0] host_data,
  output logic       host_valid,
  input wire logic  host_ready
);
  logic [7:0] q[$];
  int         gap = 0;

  initial begin
    host_valid = 1'b0;
    host_data = 8'h00;
  end
  // slow mode still stays far inside the late-byte limit
  always @(posedge clk_sys) begin
    if (rst) begin
      host_valid <= 1'b0;
    end else if (host_valid && host_ready) begin
      host_valid <= 1'b0;
      host_data <= ~host_data;
      gap = slow_mode ? 3 : 0;
    end else if (!host_valid && gap > 0) begin
      gap--;
    end else if (!host_valid && q.size() > 0) begin
      host_data <= q.pop_front();
      host_valid <= 1'b1;
    end
  end
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/1ps
module tb
  import fdc_cmd_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        cfg_we, spec_we, scan_start, skip_deleted_option, disk_valid, disk_last;
  logic        disk_deleted, host_valid, host_ready, terminal_count_pin, result_phase_evt;
  logic        seek_done_evt, seek_abnormal, sense_int_cmd, rw_cmd_start, rw_exec_end;
  logic        disk_ready, scan_busy, scan_done, int_out, request_for_master_bit;
  logic        dma_request_pin, implied_seek_req, head_load_done, head_loaded, step_tick;
  logic        slow_mode, isr;
  logic        done_seen = 1'b0;
  logic [1:0]  rate_mult, scan_mode;
  logic [7:0]  start_sector, end_track_sector, sector_step_value, disk_data, host_data;
  logic [7:0]  sector_req, sense_st0, sense_pcn, present_cylinder, rd0, rd1;
  logic [4:0]  xfer_threshold;
  logic [15:0] lf = 16'hA5D9;
  config_s     cfg_in, cfg_out;
  specify_s    spec_in, spec_out;
  result_s     scan_result;
  int          err_count = 0;
  int          total_checks = 0;
  int          n;

  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) done_seen <= scan_start ? 1'b0 : (done_seen | scan_done);

  fdc_scan_ctrl #(.OVR_CYCLES(50), .TICK_CYCLES(20)) DUT (
    .clk_sys, .rst, .cfg_we, .cfg_in, .spec_we, .spec_in, .cfg_out, .spec_out, .rate_mult,
    .scan_start, .scan_mode, .start_sector, .end_track_sector, .sector_step_value,
    .skip_deleted_option, .disk_data, .disk_valid, .disk_last, .disk_deleted, .disk_ready,
    .host_data, .host_valid, .host_ready, .terminal_count_pin, .sector_req, .scan_busy,
    .scan_done, .scan_result, .result_phase_evt, .seek_done_evt, .seek_abnormal,
    .present_cylinder, .sense_int_cmd, .sense_st0, .sense_pcn, .int_out,
    .request_for_master_bit, .dma_request_pin, .rw_cmd_start, .rw_exec_end,
    .implied_seek_req, .head_load_done, .head_loaded, .step_tick, .xfer_threshold
  );
  fdc_host_model hm (.clk_sys, .rst, .slow_mode, .host_data, .host_valid, .host_ready);

  task tk;
    @(posedge clk_sys);
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task final_report;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  function automatic logic [7:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf[7:0];
  endfunction
  task sense;
    tk; sense_int_cmd <= 1'b1;
    tk; sense_int_cmd <= 1'b0;
    tk; #1;
  endtask
  task wdone(input int lim);
    n = 0;
    #1;
    while (done_seen !== 1'b1 && n < lim) begin tk; #1; n++; end
    chk("scan_done", done_seen, 1);
    tk; #1;
  endtask
  task start(input logic [1:0] m, input logic [7:0] s0, e, st, input logic sk);
    tk; scan_mode <= m; start_sector <= s0; end_track_sector <= e;
    sector_step_value <= st; skip_deleted_option <= sk; scan_start <= 1'b1;
    tk; scan_start <= 1'b0;
  endtask
  // gives up when the scan has already ended, so early stops cannot hang it
  task dbyte(input logic [7:0] d, input logic l, del);
    tk; disk_data <= d; disk_valid <= 1'b1; disk_last <= l; disk_deleted <= del;
    n = 0;
    #1;
    while (disk_ready !== 1'b1 && n < 40 && scan_busy === 1'b1) begin tk; #1; n++; end
    tk; disk_valid <= 1'b0; disk_data <= ~d;
  endtask
  task automatic scan(input logic [1:0] m, input logic [7:0] s0, e, st, input logic sk,
                      input int pa, input int da);
    logic [7:0] sec, d, h;
    int         k;
    logic       hit, miss, mark, dn, del, ps;
    start(m, s0, e, st, sk);
    sec = s0; k = 0; hit = 0; miss = 0; mark = 0; dn = 0;
    while (!dn) begin
      del = (k == da); ps = (k == pa); mark |= del;
      tk; tk; #1;
      chk("sector_req", sector_req, sec);
      for (int i = 0; i < 4; i++) begin
        d = rnd();
        case (m)
          2'h0: h = ps ? d : ~d;
          2'h1: begin if (!ps) d = d | 8'h01; h = ps ? d + (d != 8'hFF) : d - 8'h01; end
          default: begin if (!ps) d = d & 8'hFE; h = ps ? d - (d != 8'h00) : d + 8'h01; end
        endcase
        hm.q.push_back(h);
        dbyte(d, i == 3, del);
      end
      if (del && !sk) dn = 1;
      else if (ps) begin hit = 1; dn = 1; end
      else if (sec >= e) begin miss = 1; dn = 1; end
      else begin sec = sec + st; k++; end
    end
    wdone(200);
    chk("hit", scan_result.st2[ST2_HIT_BIT], hit);
    if (!(mark && !sk)) chk("miss", scan_result.st2[ST2_MISS_BIT], miss);
    chk("mark", scan_result.st2[ST2_MARK_BIT], mark);
    chk("sector", scan_result.sector, sec);
  endtask

  initial begin
    cfg_we = 0; spec_we = 0; scan_start = 0; skip_deleted_option = 0; disk_valid = 0;
    disk_last = 0; disk_deleted = 0; terminal_count_pin = 0; result_phase_evt = 0;
    seek_done_evt = 0; seek_abnormal = 0; sense_int_cmd = 0; rw_cmd_start = 0;
    rw_exec_end = 0; slow_mode = 0; rate_mult = 2'h0; scan_mode = 2'h0; cfg_in = '0;
    spec_in = '0; start_sector = 8'h01; end_track_sector = 8'h01; sector_step_value = 8'h01;
    disk_data = 8'h00; present_cylinder = 8'h00;
    repeat (4) tk;
    rst <= 1'b0;
    tk; #1;
    chk("cfg_rst", cfg_out, {RST_IMPLIED_SEEK, RST_FIFO_DISABLE, RST_POLL_DISABLE,
                             RST_FIFO_THR, RST_PRECOMP, 1'b0});
    chk("spec_rst", spec_out, 16'h0000);
    for (int i = 0; i < 20 && int_out !== 1'b1; i++) begin tk; #1; end
    chk("poll_int", int_out, 1);
    sense;
    chk("st0_poll", sense_st0[7:5], 3'b110);
    sense;
    chk("st0_idle", sense_st0, ST0_INVALID);
    for (int a = 0; a < 2; a++) begin
      tk; present_cylinder <= 8'h2A + a; seek_abnormal <= a[0]; seek_done_evt <= 1'b1;
      tk; seek_done_evt <= 1'b0;
      tk; #1;
      chk("seek_int", int_out, 1);
      sense;
      chk("st0_seek", sense_st0[7:5], {1'b0, a[0], 1'b1});
      chk("pcn", sense_pcn, 8'h2A + a);
    end
    for (int i = 0; i < 3; i++) begin
      rd0 = rnd(); rd1 = rnd();
      tk; cfg_in <= {rd0, rd1}; cfg_we <= 1'b1;
      tk; cfg_we <= 1'b0;
      tk; #1;
      chk("cfg", cfg_out, {rd0, rd1});
      chk("thr", xfer_threshold, rd0[6] ? 5'h01 : {1'b0, rd0[4:1]} + 5'h01);
    end
    tk; cfg_in <= 16'h8000; cfg_we <= 1'b1; spec_in <= 16'h0006; spec_we <= 1'b1;
    tk; cfg_we <= 1'b0; spec_we <= 1'b0;
    tk; rw_cmd_start <= 1'b1;
    tk; rw_cmd_start <= 1'b0;
    isr = 0; n = 0;
    #1;
    while (head_load_done !== 1'b1 && n < 400) begin isr |= implied_seek_req; tk; #1; n++; end
    chk("implied_seek", isr, 1);
    chk("head_load", n >= 3 * LOAD_PER_CNT * 20 - 20 &&
        n <= 3 * LOAD_PER_CNT * 20 + 20, 1);
    tk; rw_exec_end <= 1'b1;
    tk; rw_exec_end <= 1'b0;
    n = 0;
    #1;
    while (head_loaded === 1'b1 && n < 6000) begin tk; #1; n++; end
    chk("unload", n >= UNLOAD_ZERO_CNT * 20 - 20 && n <= UNLOAD_ZERO_CNT * 20, 1);
    for (int r = 0; r < 2; r++) begin
      tk; rate_mult <= 2'(r);
      for (int i = 0; i < 2; i++) begin
        n = 0;
        do begin tk; #1; n++; end while (step_tick !== 1'b1 && n < 700);
      end
      chk("step_gap", n, STEP_BASE_TICKS * 20 * (r + 1));
    end
    scan(2'h0, 8'h01, 8'h05, 8'h01, 1'b0, 2, -1);
    scan(2'h1, 8'h01, 8'h05, 8'h02, 1'b0, -1, -1);
    slow_mode <= 1'b1;
    scan(2'h2, 8'h02, 8'h09, 8'h02, 1'b1, 3, 1);
    slow_mode <= 1'b0;
    start(2'h0, 8'h05, 8'h09, 8'h01, 1'b0);
    tk; terminal_count_pin <= 1'b1;
    wdone(30);
    chk("tc_hit", scan_result.st2[ST2_HIT_BIT], 0);
    chk("tc_sector", scan_result.sector, 8'h05);
    tk; terminal_count_pin <= 1'b0;
    start(2'h0, 8'h01, 8'h09, 8'h01, 1'b0);
    tk; disk_data <= 8'h55; disk_valid <= 1'b1;
    wdone(150);
    chk("overrun", scan_result.st1[ST1_OVERRUN_BIT], 1);
    tk; disk_valid <= 1'b0;
    for (int i = 0; i < 9; i++) hm.q.push_back(8'h11);
    repeat (30) tk;
    #1;
    chk("fifo_full", host_ready, 0);
    scan(2'h0, 8'h03, 8'h09, 8'h01, 1'b0, -1, 0);
    final_report;
  end

  initial begin
    #100000;
    err_count++;
    final_report;
  end
endmodule
